// ==== bench/pci_master_model.sv ====
// pci bus master model issuing single-phase io and memory cycles
`timescale 1ns/1ps
`default_nettype none
module pci_master_model (
    input wire logic mclk_i, // pci clock
    output logic frame_n_o, // frame, active low
    output logic [31:0] ad_o, // address/data
    output logic [3:0] cbe_n_o // command / byte enables
);
    // ****
    // cycle generator
    // ****
    initial begin
        frame_n_o = 1'b1;
        ad_o = 32'h0;
        cbe_n_o = 4'hf;
    end
    // frame is left high at the end, so the next call starts a new phase
    task automatic cycle(input logic [31:0] a, input logic [3:0] c,
        input int gap);
        for (int i = 0; i < gap; i++) begin
            @(posedge mclk_i);
            ad_o <= ~ad_o; // idle bus toggles each gap cycle, so an odd gap shows the last address again
        end
        @(posedge mclk_i);
        frame_n_o <= 1'b0;
        ad_o <= a;
        cbe_n_o <= c;
        @(posedge mclk_i);
        frame_n_o <= 1'b1;
        ad_o <= ~a;
        cbe_n_o <= 4'h0;
    endtask
endmodule // pci_master_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the pci address trap monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ****
    // signals, instances and shared tasks
    // ****
    logic mclk, rst_n, cfg_wr, cfg_rd;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata;
    logic [2:0] umask3, umask4;
    wire frame_n, s1, s2, aud, c1, c2;
    wire [31:0] ad, rdata;
    wire [3:0] cbe_n, mon;
    int failures = 0;
    int n_checks = 0;
    pci_master_model u_pci_master_model (.mclk_i(mclk),
        .frame_n_o(frame_n), .ad_o(ad), .cbe_n_o(cbe_n));
    pci_address_trap_monitor u_pci_address_trap_monitor (.mclk_i(mclk),
        .rst_n_i(rst_n), .frame_n_i(frame_n), .ad_i(ad), .cbe_n_i(cbe_n),
        .cfg_addr_i(cfg_addr), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd),
        .cfg_be_i(cfg_be), .cfg_wdata_i(cfg_wdata),
        .chip_select_zero_upper_mask_i(umask3),
        .chip_select_one_upper_mask_i(umask4), .cfg_rdata_o(rdata),
        .serial_one_trap_o(s1), .serial_two_trap_o(s2), .audio_trap_o(aud),
        .card_one_trap_o(c1), .card_two_trap_o(c2),
        .io_range_monitor_event_o(mon));
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d);
        @(posedge mclk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= d;
        @(posedge mclk);
        cfg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge mclk);
        cfg_rd <= 1'b0;
        #1 check("register read", exp, rdata);
    endtask
    // event vector: monitors 4..1, card two, card one, audio, serial two, one
    task automatic snoop(input logic [3:0] c, input logic [31:0] a,
        input logic [8:0] exp);
        u_pci_master_model.cycle(a, c, n_checks % 3);
        #1 check("trap events", {23'h0, exp}, {23'h0, mon, c2, c1, aud, s2, s1});
    endtask
    task automatic t_reset_values();
        logic [31:0] exp [12];
        exp = '{0: 32'h02f803f8, 1: 32'h00000f0f, 2: 32'h03300220,
            3: 32'h03880530, 4: 32'h0707010f, default: 32'h0};
        for (int i = 0; i < 12; i++) begin
            rd_chk(8'ha0 + 8'(4 * i), exp[i]);
        end
        rd_chk(8'hd0, 32'h0);
        rd_chk(8'ha1, 32'h0);
    endtask
    task automatic t_defaults();
        logic [44:0] tab [18];
        tab = '{{4'h2, 32'h3f8, 9'h001}, {4'h3, 32'h3f0, 9'h001},
            {4'h2, 32'h3e8, 9'h000}, {4'h2, 32'h13f8, 9'h000},
            {4'h3, 32'h2ff, 9'h002}, {4'h6, 32'h3f8, 9'h018},
            {4'h7, 32'h400, 9'h000}, {4'h2, 32'h0, 9'h1f8},
            {4'h0, 32'h3f8, 9'h000}, {4'hb, 32'h3f8, 9'h000},
            {4'h2, 32'h22f, 9'h004}, {4'h3, 32'h331, 9'h004},
            {4'h2, 32'h332, 9'h000}, {4'h2, 32'h537, 9'h004},
            {4'h3, 32'h38f, 9'h004}, {4'hc, 32'h0, 9'h018},
            {4'he, 32'h0, 9'h018}, {4'hf, 32'h3ff, 9'h018}};
        for (int i = 0; i < 18; i++) begin
            snoop(tab[i][44:41], tab[i][40:9], tab[i][8:0]);
        end
    endtask
    task automatic t_reg_write();
        logic [7:0] a;
        for (int i = 0; i < 12; i++) begin
            a = 8'ha0 + 8'(4 * i);
            wr(a, 4'hf, 32'hffffffff);
            rd_chk(a, a == 8'ha4 ? 32'h0000ffff : (a == 8'hb8 || a == 8'hbc)
                ? 32'hfffffc00 : 32'hffffffff);
        end
        wr(8'ha0, 4'h1, 32'h12345678);
        rd_chk(8'ha0, 32'hffffff78);
        wr(8'hd0, 4'hf, 32'hffffffff);
        rd_chk(8'hd0, 32'h0);
        snoop(4'h3, 32'hff00, 9'h1ff);
        snoop(4'h3, 32'hfe00, 9'h000);
    endtask
    task automatic t_card();
        wr(8'hb4, 4'hf, 32'h12000300);
        wr(8'hb8, 4'hf, 32'h80000000);
        wr(8'hbc, 4'hf, 32'h0);
        wr(8'hc0, 4'hf, 32'h00ff000f);
        snoop(4'h2, 32'h30a, 9'h008);
        snoop(4'h3, 32'h310, 9'h000);
        snoop(4'h2, 32'h1200, 9'h010);
        snoop(4'h2, 32'h1201, 9'h000);
        snoop(4'h6, 32'h80000000, 9'h008);
        snoop(4'h7, 32'h8003fc00, 9'h008);
        snoop(4'hc, 32'h80040000, 9'h000);
        snoop(4'h2, 32'h80000000, 9'h000);
        snoop(4'h6, 32'h30a, 9'h010);
    endtask
    task automatic t_monitor();
        wr(8'hc4, 4'hf, 32'h04000100);
        wr(8'hc8, 4'hf, 32'h08000600);
        wr(8'hcc, 4'hf, 32'h03030303);
        snoop(4'h2, 32'h103, 9'h020);
        snoop(4'h3, 32'h403, 9'h040);
        snoop(4'h2, 32'h603, 9'h080);
        snoop(4'h2, 32'h803, 9'h100);
        snoop(4'h2, 32'h703, 9'h000);
        snoop(4'h7, 32'h103, 9'h010);
        @(posedge mclk);
        umask3 <= 3'b001;
        umask4 <= 3'b011;
        snoop(4'h2, 32'h703, 9'h080);
        snoop(4'h3, 32'hb03, 9'h100);
        snoop(4'h2, 32'h203, 9'h000);
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        rst_n = 1'b0;
        {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = '0;
        {umask3, umask4} = '0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset_values();
        t_defaults();
        t_reg_write();
        t_card();
        t_monitor();
        tally_and_finish();
    end
    // whole run is a few hundred cycles; this only cuts a hang short
    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire

// ==== bench/trap_monitor_chk.sv ====
// assertion checker for the pci address trap monitor
`timescale 1ns/1ps
`default_nettype none
module trap_monitor_chk (
    input wire logic mclk_i, // pci clock
    input wire logic rst_n_i, // reset, active low
    input wire logic frame_n_i, // frame, active low
    input wire logic [31:0] ad_i, // address/data
    input wire logic [3:0] cbe_n_i, // command
    input wire logic [7:0] cfg_addr_i, // register offset
    input wire logic cfg_wr_i, // write strobe
    input wire logic cfg_rd_i, // read strobe
    input wire logic [3:0] cfg_be_i, // byte enables
    input wire logic [31:0] cfg_wdata_i, // write data
    input wire logic [31:0] cfg_rdata_o, // read data
    input wire logic serial_one_trap_o, // trap
    input wire logic serial_two_trap_o, // trap
    input wire logic audio_trap_o, // trap
    input wire logic card_one_trap_o, // trap
    input wire logic card_two_trap_o, // trap
    input wire logic [3:0] io_range_monitor_event_o // traps
);
    // ****
    // serial register mirror, so matches are judged at the pins
    // ****
    logic prev_q, ph, io, mem, io_ev, any_ev, hit1, hit2;
    logic [31:0] sa_q;
    logic [31:0] sm_q;
    assign ph = !frame_n_i && prev_q;
    assign io = cbe_n_i inside {4'h2, 4'h3};
    assign mem = cbe_n_i inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf};
    assign io_ev = serial_one_trap_o | serial_two_trap_o | audio_trap_o
        | (|io_range_monitor_event_o);
    assign any_ev = io_ev | card_one_trap_o | card_two_trap_o;
    assign hit1 = (ad_i[15:0] | {8'h00, sm_q[7:0]})
        == (sa_q[15:0] | {8'h00, sm_q[7:0]});
    assign hit2 = (ad_i[15:0] | {8'h00, sm_q[15:8]})
        == (sa_q[31:16] | {8'h00, sm_q[15:8]});
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_q <= 1'b1;
            sa_q <= 32'h02f803f8;
            sm_q <= 32'h00000f0f;
        end else begin
            prev_q <= frame_n_i;
            for (int i = 0; i < 4; i++) begin
                if (cfg_wr_i && cfg_be_i[i] && cfg_addr_i == 8'ha0) begin
                    sa_q[8*i+:8] <= cfg_wdata_i[8*i+:8];
                end
                if (cfg_wr_i && cfg_be_i[i] && cfg_addr_i == 8'ha4) begin
                    sm_q[8*i+:8] <= cfg_wdata_i[8*i+:8];
                end
            end
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    AST_SER_ONE: assert property (ph && io |=>
        serial_one_trap_o == $past(hit1)) else $error("serial one trap");
    AST_SER_TWO: assert property (ph && io |=>
        serial_two_trap_o == $past(hit2)) else $error("serial two trap");
    AST_AFTER_ADDR: assert property (any_ev |-> $past(ph))
        else $error("event without address phase");
    AST_ONE_CYCLE: assert property (any_ev |=> !any_ev)
        else $error("event longer than one cycle");
    AST_MEM_NO_IO: assert property (ph && mem |=> !io_ev)
        else $error("io trap on memory cycle");
    AST_OTHER_SILENT: assert property (ph && !io && !mem |=> !any_ev)
        else $error("trap on other command");
    AST_UNMAPPED: assert property (cfg_rd_i && (cfg_addr_i < 8'ha0 ||
        cfg_addr_i > 8'hcc || cfg_addr_i[1:0] != 2'b00) |=> cfg_rdata_o == 0)
        else $error("unmapped read not zero");
    AST_MASK_READ: assert property (cfg_rd_i && cfg_addr_i == 8'ha4 |=>
        cfg_rdata_o == {16'h0000, $past(sm_q[15:0])}) else $error("mask read");
    AST_MEM_RSVD: assert property (cfg_rd_i && cfg_addr_i[7:2]
        inside {6'h2e, 6'h2f} |=> cfg_rdata_o[9:0] == 10'h000)
        else $error("reserved bits read back");
endmodule // trap_monitor_chk

bind pci_address_trap_monitor trap_monitor_chk u_trap_monitor_chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .frame_n_i(frame_n_i), .ad_i(ad_i),
    .cbe_n_i(cbe_n_i), .cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .serial_one_trap_o(serial_one_trap_o),
    .serial_two_trap_o(serial_two_trap_o), .audio_trap_o(audio_trap_o),
    .card_one_trap_o(card_one_trap_o), .card_two_trap_o(card_two_trap_o),
    .io_range_monitor_event_o(io_range_monitor_event_o));
`default_nettype wire

// ==== core/pci_address_trap_monitor.v ====
// pci address trap monitor: snoops address phases, raises trap pulses
`include "trap_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module pci_address_trap_monitor (
    input wire mclk_i, // pci clock, 50 mhz
    input wire rst_n_i, // asynchronous reset, active low
    input wire frame_n_i, // pci frame#, active low
    input wire [31:0] ad_i, // pci address/data
    input wire [3:0] cbe_n_i, // pci command / byte enables
    input wire [7:0] cfg_addr_i, // configuration register offset
    input wire cfg_wr_i, // configuration write strobe
    input wire cfg_rd_i, // configuration read strobe
    input wire [3:0] cfg_be_i, // configuration byte enables
    input wire [31:0] cfg_wdata_i, // configuration write data
    input wire [2:0] chip_select_zero_upper_mask_i, // monitor 3 bits 10:8
    input wire [2:0] chip_select_one_upper_mask_i, // monitor 4 bits 10:8
    output reg [31:0] cfg_rdata_o, // configuration read data
    output reg serial_one_trap_o, // serial port one trap pulse
    output reg serial_two_trap_o, // serial port two trap pulse
    output reg audio_trap_o, // audio trap pulse
    output reg card_one_trap_o, // card one trap pulse
    output reg card_two_trap_o, // card two trap pulse
    output reg [3:0] io_range_monitor_event_o // range monitor pulses
);

    // ****************************************************************
    // register file
    // ****************************************************************
    function [31:0] reset_val;
        input integer idx;
        begin
            case (idx)
                `IDX_SERIAL_ADDR: reset_val = `RST_SERIAL_ADDR;
                `IDX_SERIAL_MASK: reset_val = `RST_SERIAL_MASK;
                `IDX_AUDIO_ADDR_LO: reset_val = `RST_AUDIO_ADDR_LO;
                `IDX_AUDIO_ADDR_HI: reset_val = `RST_AUDIO_ADDR_HI;
                `IDX_AUDIO_MASK: reset_val = `RST_AUDIO_MASK;
                `IDX_CARD_IO_ADDR: reset_val = `RST_ZERO;
                `IDX_CARD_ONE_MEM: reset_val = `RST_ZERO;
                `IDX_CARD_TWO_MEM: reset_val = `RST_ZERO;
                `IDX_CARD_MASK: reset_val = `RST_ZERO;
                `IDX_MON_ADDR_LO: reset_val = `RST_ZERO;
                `IDX_MON_ADDR_HI: reset_val = `RST_ZERO;
                `IDX_MON_MASK: reset_val = `RST_ZERO;
                default: reset_val = `RST_ZERO;
            endcase
        end
    endfunction

    // reserved bits are never stored, so they always read back as zero
    function [31:0] write_mask;
        input integer idx;
        begin
            case (idx)
                `IDX_SERIAL_MASK: write_mask = `WR_HALF;
                `IDX_CARD_ONE_MEM: write_mask = `WR_MEM_ADDR;
                `IDX_CARD_TWO_MEM: write_mask = `WR_MEM_ADDR;
                `IDX_SERIAL_ADDR: write_mask = `WR_ALL;
                `IDX_AUDIO_ADDR_LO: write_mask = `WR_ALL;
                `IDX_AUDIO_ADDR_HI: write_mask = `WR_ALL;
                `IDX_AUDIO_MASK: write_mask = `WR_ALL;
                `IDX_CARD_IO_ADDR: write_mask = `WR_ALL;
                `IDX_CARD_MASK: write_mask = `WR_ALL;
                `IDX_MON_ADDR_LO: write_mask = `WR_ALL;
                `IDX_MON_ADDR_HI: write_mask = `WR_ALL;
                `IDX_MON_MASK: write_mask = `WR_ALL;
                default: write_mask = `WR_ALL;
            endcase
        end
    endfunction

    wire [31:0] be_bits;
    reg [3:0] reg_idx;
    reg reg_hit;

    // full-offset decode: unaligned and out-of-range offsets never hit
    always @* begin
        reg_hit = 1'b1;
        reg_idx = `IDX_SERIAL_ADDR;
        if (cfg_addr_i == `OFS_SERIAL_ADDR) begin
            reg_idx = `IDX_SERIAL_ADDR;
        end else if (cfg_addr_i == `OFS_SERIAL_MASK) begin
            reg_idx = `IDX_SERIAL_MASK;
        end else if (cfg_addr_i == `OFS_AUDIO_ADDR_LO) begin
            reg_idx = `IDX_AUDIO_ADDR_LO;
        end else if (cfg_addr_i == `OFS_AUDIO_ADDR_HI) begin
            reg_idx = `IDX_AUDIO_ADDR_HI;
        end else if (cfg_addr_i == `OFS_AUDIO_MASK) begin
            reg_idx = `IDX_AUDIO_MASK;
        end else if (cfg_addr_i == `OFS_CARD_IO_ADDR) begin
            reg_idx = `IDX_CARD_IO_ADDR;
        end else if (cfg_addr_i == `OFS_CARD_ONE_MEM) begin
            reg_idx = `IDX_CARD_ONE_MEM;
        end else if (cfg_addr_i == `OFS_CARD_TWO_MEM) begin
            reg_idx = `IDX_CARD_TWO_MEM;
        end else if (cfg_addr_i == `OFS_CARD_MASK) begin
            reg_idx = `IDX_CARD_MASK;
        end else if (cfg_addr_i == `OFS_MON_ADDR_LO) begin
            reg_idx = `IDX_MON_ADDR_LO;
        end else if (cfg_addr_i == `OFS_MON_ADDR_HI) begin
            reg_idx = `IDX_MON_ADDR_HI;
        end else if (cfg_addr_i == `OFS_MON_MASK) begin
            reg_idx = `IDX_MON_MASK;
        end else begin
            reg_hit = 1'b0;
        end
    end

    assign be_bits = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}},
                      {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};

    reg [31:0] regs_q [0:`REG_COUNT-1];

    genvar g;
    generate
        for (g = 0; g < `REG_COUNT; g = g + 1) begin : g_reg
            localparam [3:0] reg_slot = g;
            wire [31:0] keep;
            wire [31:0] wmask;
            assign wmask = write_mask(g);
            assign keep = be_bits & wmask;
            always @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    regs_q[g] <= reset_val(g);
                end else if (cfg_wr_i && reg_hit &&
                             (reg_idx == reg_slot)) begin
                    regs_q[g] <= (regs_q[g] & ~keep) |
                                 (cfg_wdata_i & keep);
                end
            end
        end
    endgenerate

    // read data is held until the next read so software sees a stable word
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_rdata_o <= `RST_ZERO;
        end else if (cfg_rd_i) begin
            if (reg_hit) begin
                cfg_rdata_o <= regs_q[reg_idx];
            end else begin
                cfg_rdata_o <= `RST_ZERO;
            end
        end
    end

    // ****************************************************************
    // address phase detection
    // ****************************************************************
    reg frame_prev_n_q;
    wire addr_phase;
    reg io_space;
    reg mem_space;

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frame_prev_n_q <= 1'b1;
        end else begin
            frame_prev_n_q <= frame_n_i;
        end
    end

    // every cycle on the bus is looked at; no target decode gates it
    assign addr_phase = frame_prev_n_q && !frame_n_i;

    // config, special and interrupt-acknowledge cycles never match
    always @* begin
        io_space = 1'b0;
        mem_space = 1'b0;
        case (cbe_n_i)
            `CMD_IO_READ: io_space = 1'b1;
            `CMD_IO_WRITE: io_space = 1'b1;
            `CMD_MEM_READ: mem_space = 1'b1;
            `CMD_MEM_WRITE: mem_space = 1'b1;
            `CMD_MEM_READ_MULT: mem_space = 1'b1;
            `CMD_MEM_READ_LINE: mem_space = 1'b1;
            `CMD_MEM_WRITE_INV: mem_space = 1'b1;
            default: begin
                io_space = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // io comparators
    // ****************************************************************
    wire [31:0] serial_addr = regs_q[`IDX_SERIAL_ADDR];
    wire [31:0] serial_mask = regs_q[`IDX_SERIAL_MASK];
    wire [31:0] audio_lo = regs_q[`IDX_AUDIO_ADDR_LO];
    wire [31:0] audio_hi = regs_q[`IDX_AUDIO_ADDR_HI];
    wire [31:0] audio_mask = regs_q[`IDX_AUDIO_MASK];
    wire [31:0] card_io = regs_q[`IDX_CARD_IO_ADDR];
    wire [31:0] card_mask = regs_q[`IDX_CARD_MASK];
    wire [31:0] mon_lo = regs_q[`IDX_MON_ADDR_LO];
    wire [31:0] mon_hi = regs_q[`IDX_MON_ADDR_HI];
    wire [31:0] mon_mask = regs_q[`IDX_MON_MASK];

    wire [15:0] cmp_addr [0:`IO_CMP_COUNT-1];
    wire [15:0] cmp_mask [0:`IO_CMP_COUNT-1];
    wire [`IO_CMP_COUNT-1:0] io_hit;

    // eight-bit masks are zero extended, so bits 15:8 compare exactly, except monitors 3 and 4, whose bits 10:8 come from the upper mask inputs
    assign cmp_addr[0] = serial_addr[15:0];
    assign cmp_mask[0] = {8'h00, serial_mask[7:0]};
    assign cmp_addr[1] = serial_addr[31:16];
    assign cmp_mask[1] = {8'h00, serial_mask[15:8]};
    assign cmp_addr[2] = audio_lo[15:0];
    assign cmp_mask[2] = {8'h00, audio_mask[7:0]};
    assign cmp_addr[3] = audio_lo[31:16];
    assign cmp_mask[3] = {8'h00, audio_mask[15:8]};
    assign cmp_addr[4] = audio_hi[15:0];
    assign cmp_mask[4] = {8'h00, audio_mask[23:16]};
    assign cmp_addr[5] = audio_hi[31:16];
    assign cmp_mask[5] = {8'h00, audio_mask[31:24]};
    assign cmp_addr[6] = card_io[15:0];
    assign cmp_mask[6] = {8'h00, card_mask[7:0]};
    assign cmp_addr[7] = card_io[31:16];
    assign cmp_mask[7] = {8'h00, card_mask[15:8]};
    assign cmp_addr[8] = mon_lo[15:0];
    assign cmp_mask[8] = {8'h00, mon_mask[7:0]};
    assign cmp_addr[9] = mon_lo[31:16];
    assign cmp_mask[9] = {8'h00, mon_mask[15:8]};
    assign cmp_addr[10] = mon_hi[15:0];
    assign cmp_mask[10] = {5'h00, chip_select_zero_upper_mask_i,
                           mon_mask[23:16]};
    assign cmp_addr[11] = mon_hi[31:16];
    assign cmp_mask[11] = {5'h00, chip_select_one_upper_mask_i,
                           mon_mask[31:24]};

    generate
        for (g = 0; g < `IO_CMP_COUNT; g = g + 1) begin : g_io_cmp
            // set mask bits force both sides high, so they never differ
            assign io_hit[g] = io_space &&
                ((ad_i[15:0] | cmp_mask[g]) ==
                 (cmp_addr[g] | cmp_mask[g]));
        end
    endgenerate

    // ****************************************************************
    // card memory comparators
    // ****************************************************************
    wire [21:0] mem_one_mask = {14'h0000, card_mask[23:16]};
    wire [21:0] mem_two_mask = {14'h0000, card_mask[31:24]};
    wire [21:0] mem_one_addr = regs_q[`IDX_CARD_ONE_MEM][31:10];
    wire [21:0] mem_two_addr = regs_q[`IDX_CARD_TWO_MEM][31:10];
    wire mem_one_hit;
    wire mem_two_hit;

    assign mem_one_hit = mem_space &&
        ((ad_i[31:10] | mem_one_mask) ==
         (mem_one_addr | mem_one_mask));
    assign mem_two_hit = mem_space &&
        ((ad_i[31:10] | mem_two_mask) ==
         (mem_two_addr | mem_two_mask));

    // ****************************************************************
    // event pulses
    // ****************************************************************
    // events are registered so downstream interrupt and timer logic
    // sees a clean one-cycle pulse one edge after the address phase
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_one_trap_o <= 1'b0;
        end else begin
            serial_one_trap_o <= addr_phase &&
                io_hit[`CMP_SERIAL_ONE];
        end
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_two_trap_o <= 1'b0;
        end else begin
            serial_two_trap_o <= addr_phase &&
                io_hit[`CMP_SERIAL_TWO];
        end
    end

    // the four audio windows share one event; software cannot tell which
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            audio_trap_o <= 1'b0;
        end else begin
            audio_trap_o <= addr_phase &&
                (|io_hit[`CMP_AUDIO_FIRST+3:`CMP_AUDIO_FIRST]);
        end
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            card_one_trap_o <= 1'b0;
        end else begin
            card_one_trap_o <= addr_phase &&
                (io_hit[`CMP_CARD_ONE] || mem_one_hit);
        end
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            card_two_trap_o <= 1'b0;
        end else begin
            card_two_trap_o <= addr_phase &&
                (io_hit[`CMP_CARD_TWO] || mem_two_hit);
        end
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            io_range_monitor_event_o <= 4'h0;
        end else begin
            io_range_monitor_event_o <= {4{addr_phase}} &
                io_hit[`CMP_MON_FIRST+3:`CMP_MON_FIRST];
        end
    end

endmodule // pci_address_trap_monitor

`default_nettype wire

// ==== core/trap_regs.vh ====
// constants for the pci address trap monitor
`ifndef TRAP_REGS_VH
`define TRAP_REGS_VH

// ********************************************************************
// register offsets (byte addresses in configuration space)
// ********************************************************************
`define OFS_SERIAL_ADDR 8'ha0
`define OFS_SERIAL_MASK 8'ha4
`define OFS_AUDIO_ADDR_LO 8'ha8
`define OFS_AUDIO_ADDR_HI 8'hac
`define OFS_AUDIO_MASK 8'hb0
`define OFS_CARD_IO_ADDR 8'hb4
`define OFS_CARD_ONE_MEM 8'hb8
`define OFS_CARD_TWO_MEM 8'hbc
`define OFS_CARD_MASK 8'hc0
`define OFS_MON_ADDR_LO 8'hc4
`define OFS_MON_ADDR_HI 8'hc8
`define OFS_MON_MASK 8'hcc
`define OFS_FIRST_WORD 6'h28
`define REG_COUNT 12

// ********************************************************************
// register indices
// ********************************************************************
`define IDX_SERIAL_ADDR 4'h0
`define IDX_SERIAL_MASK 4'h1
`define IDX_AUDIO_ADDR_LO 4'h2
`define IDX_AUDIO_ADDR_HI 4'h3
`define IDX_AUDIO_MASK 4'h4
`define IDX_CARD_IO_ADDR 4'h5
`define IDX_CARD_ONE_MEM 4'h6
`define IDX_CARD_TWO_MEM 4'h7
`define IDX_CARD_MASK 4'h8
`define IDX_MON_ADDR_LO 4'h9
`define IDX_MON_ADDR_HI 4'ha
`define IDX_MON_MASK 4'hb
`define IDX_LAST 4'hb

// ********************************************************************
// reset values and writable bits
// ********************************************************************
`define RST_SERIAL_ADDR 32'h02f803f8
`define RST_SERIAL_MASK 32'h00000f0f
`define RST_AUDIO_ADDR_LO 32'h03300220
`define RST_AUDIO_ADDR_HI 32'h03880530
`define RST_AUDIO_MASK 32'h0707010f
`define RST_ZERO 32'h00000000
`define WR_ALL 32'hffffffff
`define WR_HALF 32'h0000ffff
`define WR_MEM_ADDR 32'hfffffc00

// ********************************************************************
// pci bus commands (c/be# during the address phase)
// ********************************************************************
`define CMD_IO_READ 4'h2
`define CMD_IO_WRITE 4'h3
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define CMD_MEM_READ_MULT 4'hc
`define CMD_MEM_READ_LINE 4'he
`define CMD_MEM_WRITE_INV 4'hf

// ********************************************************************
// comparator layout
// ********************************************************************
`define IO_CMP_COUNT 12
`define CMP_SERIAL_ONE 0
`define CMP_SERIAL_TWO 1
`define CMP_AUDIO_FIRST 2
`define CMP_CARD_ONE 6
`define CMP_CARD_TWO 7
`define CMP_MON_FIRST 8

`endif
